// ===== design/dbc_top.sv
`timescale 1ns/1ps
module dbc_top #(
  parameter int unsigned WAKE_CYC = dbc_pkg::WAKE_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // bridge control, level and analog comparator indications
  input wire dbc_pkg::dbc_bridge_in_s i_bridge_a,
  input wire dbc_pkg::dbc_bridge_in_s i_bridge_b,
  // shared decay pin, seen as two level detectors
  input wire logic i_decay_low,
  input wire logic i_decay_high,
  // global control and supervision
  input wire logic i_logic_clear_n,
  input wire logic i_low_power_request_n,
  input wire logic i_overtemp_shutdown,
  input wire logic i_supply_lockout,
  // gate drive
  output dbc_pkg::dbc_bridge_s o_bridge_a_drive,
  output dbc_pkg::dbc_bridge_s o_bridge_b_drive,
  // chopping comparator control
  output logic [1:0] o_ref_scale_a,
  output logic [1:0] o_ref_scale_b,
  output logic [1:0] o_sense_arm,
  // power and status
  output logic o_charge_pump_en,
  output logic o_regulator_en,
  output logic [1:0] o_overcurrent_shutdown,
  output logic o_protection_alert_n,
  output logic o_protection_alert_oe
);

  localparam int SW = $bits(dbc_pkg::dbc_pins_s);
  localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYC);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SW-1:0] raw;
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic [SW-1:0] s3;
  logic [SW-1:0] filt;
  dbc_pkg::dbc_pins_s pin;
  dbc_pkg::dbc_bridge_in_s br [2];

  assign raw = {i_bridge_a, i_bridge_b, i_decay_low, i_decay_high,
                i_logic_clear_n, i_low_power_request_n,
                i_overtemp_shutdown, i_supply_lockout};

  // a bit only moves once the second and third stages agree
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      filt <= (s2 & s3) | (filt & (s2 | s3));
    end
  end

  assign pin = dbc_pkg::dbc_pins_s'(filt);
  assign br[0] = pin.a;
  assign br[1] = pin.b;

  // ----------------------------------------------------------------
  // global state
  // ----------------------------------------------------------------
  logic clear;
  logic sleeping;
  logic wake_done;
  logic run;
  logic period_start;
  logic [15:0] wake_cnt;
  logic [9:0] chop_cnt;
  dbc_pkg::dbc_decay_e mode;

  assign clear = ~pin.logic_clear_n | pin.supply_lockout;
  assign sleeping = ~pin.low_power_request_n;
  assign wake_done = (wake_cnt == WAKE_LAST);
  assign run = ~clear & ~sleeping & wake_done;
  assign period_start = run & (chop_cnt == dbc_pkg::CHOP_LAST);

  always_comb begin
    if (pin.decay_low) begin
      mode = dbc_pkg::DEC_SLOW;
    end else if (pin.decay_high) begin
      mode = dbc_pkg::DEC_FAST;
    end else begin
      mode = dbc_pkg::DEC_MIXED;
    end
  end

  // wake delay
  // bridges stay off until the wake interval has run out
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_cnt <= '0;
    end else if (sleeping) begin
      wake_cnt <= '0;
    end else if (!wake_done) begin
      wake_cnt <= wake_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chop_cnt <= '0;
    end else if (!run || period_start) begin
      chop_cnt <= '0;
    end else begin
      chop_cnt <= chop_cnt + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // per-bridge chopping
  // ----------------------------------------------------------------
  function automatic dbc_pkg::dbc_bridge_s drive_of(
    input dbc_pkg::dbc_phase_e ph,
    input logic c1,
    input logic c2
  );
    dbc_pkg::dbc_bridge_s d;
    d = '0;
    unique case (ph)
      dbc_pkg::PH_DRIVE: begin
        d.drive_first = '{hs_on: c1, ls_on: ~c1};
        d.drive_second = '{hs_on: c2, ls_on: ~c2};
      end
      dbc_pkg::PH_FAST: begin
        d.drive_first = '{hs_on: ~c1, ls_on: c1};
        d.drive_second = '{hs_on: ~c2, ls_on: c2};
      end
      dbc_pkg::PH_SLOW: begin
        d.drive_first = '{hs_on: 1'b0, ls_on: 1'b1};
        d.drive_second = '{hs_on: 1'b0, ls_on: 1'b1};
      end
      dbc_pkg::PH_OFF: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  logic [1:0] overcurrent_shutdown;
  logic [1:0] en;
  logic [1:0] level [2];
  logic [7:0] blank [2];
  logic [7:0] ocp_cnt [2];
  dbc_pkg::dbc_phase_e phase [2];
  dbc_pkg::dbc_bridge_s drv [2];
  logic mix_hit;

  assign mix_hit = (mode == dbc_pkg::DEC_MIXED) &
                   (chop_cnt == dbc_pkg::MIX_AT);

  for (genvar k = 0; k < 2; k++) begin : g_br
    assign level[k] = {br[k].current_level_msb, br[k].current_level_lsb};
    assign en[k] = run & ~pin.overtemp_shutdown & ~overcurrent_shutdown[k] &
                   (level[k] != dbc_pkg::LEVEL_OFF);
    assign drv[k] = drive_of(phase[k], br[k].ctl_first, br[k].ctl_second);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 2; k++) begin
        phase[k] <= dbc_pkg::PH_DRIVE;
        blank[k] <= dbc_pkg::BLANK_LOAD;
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (!en[k] || period_start) begin
          phase[k] <= dbc_pkg::PH_DRIVE;
          blank[k] <= dbc_pkg::BLANK_LOAD;
        end else begin
          unique case (phase[k])
            dbc_pkg::PH_DRIVE: begin
              if (blank[k] != 8'h00) begin
                blank[k] <= blank[k] - 8'h01;
              end else if (br[k].chop_trip) begin
                phase[k] <= (mode == dbc_pkg::DEC_SLOW) ?
                            dbc_pkg::PH_SLOW : dbc_pkg::PH_FAST;
              end
            end
            dbc_pkg::PH_FAST: begin
              if (mix_hit) begin
                phase[k] <= dbc_pkg::PH_SLOW;
              end else if (br[k].near_zero) begin
                phase[k] <= dbc_pkg::PH_OFF;
              end
            end
            dbc_pkg::PH_OFF: begin
              if (mix_hit) begin
                phase[k] <= dbc_pkg::PH_SLOW;
              end
            end
            dbc_pkg::PH_SLOW: begin
              phase[k] <= dbc_pkg::PH_SLOW;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // overcurrent qualification and latch
  // ----------------------------------------------------------------
  // only the per-switch limit flag is looked at, never the chop path
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overcurrent_shutdown <= '0;
      for (int k = 0; k < 2; k++) begin
        ocp_cnt[k] <= '0;
      end
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (clear) begin
          overcurrent_shutdown[k] <= 1'b0;
          ocp_cnt[k] <= '0;
        end else if (!sleeping && !overcurrent_shutdown[k]) begin
          if (!br[k].switch_limit) begin
            ocp_cnt[k] <= '0;
          end else if (ocp_cnt[k] == dbc_pkg::OCP_LIMIT) begin
            overcurrent_shutdown[k] <= 1'b1;
          end else begin
            ocp_cnt[k] <= ocp_cnt[k] + 8'h01;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic fault;
  assign fault = (|overcurrent_shutdown) | pin.overtemp_shutdown | pin.supply_lockout;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bridge_a_drive <= '0;
      o_bridge_b_drive <= '0;
      o_sense_arm <= '0;
    end else begin
      o_bridge_a_drive <= en[0] ? drv[0] : '0;
      o_bridge_b_drive <= en[1] ? drv[1] : '0;
      for (int k = 0; k < 2; k++) begin
        o_sense_arm[k] <= en[k] & (phase[k] == dbc_pkg::PH_DRIVE) &
                          (blank[k] == 8'h00);
      end
    end
  end

  // reference scale
  // inputs are ignored while cleared or asleep, so the code holds
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ref_scale_a <= dbc_pkg::LEVEL_OFF;
      o_ref_scale_b <= dbc_pkg::LEVEL_OFF;
    end else if (!clear && !sleeping) begin
      o_ref_scale_a <= level[0];
      o_ref_scale_b <= level[1];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_charge_pump_en <= 1'b0;
      o_regulator_en <= 1'b0;
    end else begin
      o_charge_pump_en <= ~sleeping & ~pin.supply_lockout;
      o_regulator_en <= ~sleeping & ~pin.supply_lockout;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overcurrent_shutdown <= '0;
      o_protection_alert_n <= 1'b1;
      o_protection_alert_oe <= 1'b0;
    end else begin
      o_overcurrent_shutdown <= overcurrent_shutdown;
      o_protection_alert_n <= ~fault;
      o_protection_alert_oe <= fault;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_trip_ready;
    en[0] && !period_start && phase[0] == dbc_pkg::PH_DRIVE &&
      blank[0] == 8'h00 && br[0].chop_trip;
  endsequence

  sequence s_fast_hold;
    en[0] && !period_start && phase[0] == dbc_pkg::PH_FAST;
  endsequence

  a_direct_follow: assert property (
    en[0] && phase[0] == dbc_pkg::PH_DRIVE |=>
      o_bridge_a_drive.drive_first.hs_on == $past(br[0].ctl_first) &&
      o_bridge_a_drive.drive_second.ls_on == !$past(br[0].ctl_second))
    else $error("bridge a does not follow its controls");

  a_trip_decay: assert property (
    s_trip_ready and (mode != dbc_pkg::DEC_SLOW) |=>
      phase[0] == dbc_pkg::PH_FAST ##1
      (!$past(en[0]) || o_bridge_a_drive.drive_first.hs_on ==
                        !$past(br[0].ctl_first)))
    else $error("trip did not start fast decay");

  a_slow_recirc: assert property (
    en[0] && phase[0] == dbc_pkg::PH_SLOW |=>
      o_bridge_a_drive == 4'h5)
    else $error("slow decay not on both low sides");

  a_mixed_switch: assert property (
    s_fast_hold and mix_hit |=> phase[0] == dbc_pkg::PH_SLOW)
    else $error("mixed decay missed slow switch");

  a_blank_hold: assert property (
    $rose(en[0]) |-> (phase[0] == dbc_pkg::PH_DRIVE &&
                      blank[0] == dbc_pkg::BLANK_LOAD) ##1
      (!o_sense_arm[0]) [*8])
    else $error("sense armed inside blanking");

  a_level_off: assert property (
    level[0] == dbc_pkg::LEVEL_OFF |=> o_bridge_a_drive == '0)
    else $error("bridge driven with level off");

  a_clear_off: assert property (
    clear |=> o_bridge_a_drive == '0 && o_bridge_b_drive == '0 &&
              overcurrent_shutdown == '0)
    else $error("clear did not disable bridges");

  a_sleep_off: assert property (
    sleeping |=> !o_charge_pump_en && o_bridge_b_drive == '0)
    else $error("sleep left power stage running");

  a_ocp_latch: assert property (
    overcurrent_shutdown[1] && !clear |=> overcurrent_shutdown[1] && o_protection_alert_oe)
    else $error("overcurrent latch lost");

  a_ocp_qual: assert property (
    $rose(overcurrent_shutdown[0]) |-> $past(br[0].switch_limit) &&
      $past(ocp_cnt[0]) == dbc_pkg::OCP_LIMIT)
    else $error("overcurrent latched unqualified");

  a_tsd_alert: assert property (
    pin.overtemp_shutdown |=> !o_protection_alert_n &&
      o_bridge_a_drive == '0)
    else $error("overtemp not shut down");

  a_alert_free: assert property (
    !fault |=> o_protection_alert_n && !o_protection_alert_oe)
    else $error("alert held without cause");

  a_period_restart: assert property (
    period_start && en[1] |=> phase[1] == dbc_pkg::PH_DRIVE &&
      chop_cnt == 10'h000)
    else $error("period boundary missed restart");

endmodule

// ===== design/dbc_pkg.sv
// Operation
// - each output follows its control input directly
// - trip stops drive until next chopping period
// - trip compares sense times five with reference
// - level code scales reference; eleven disables bridge
// - shared decay pin: low slow, open mixed, high fast
// - fast decay reverses bridge, off near zero
// - slow decay turns both low sides on
// - mixed: fast first, slow from 75% of period
// - ignore sense for 3.75 us after enable
// - blanking also sets minimum on-time
// - clear input resets logic, disables, ignores inputs
// - sleep disables bridges, pump, regulator, clocks (here no clock is gated; i_mclk keeps running)
// - persistent switch limit disables bridge, asserts alert
// - overcurrent shutdown latched until clear or repower
// - overcurrent independent of chopping sense path
// - overtemperature disables, alerts, resumes automatically
// - supply lockout disables all and resets logic
package dbc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int CHOP_PERIOD_NS = 20000;
  localparam int CHOP_CYC = CHOP_PERIOD_NS / CLK_NS;
  localparam int MIX_PCT = 75;
  localparam int MIX_CYC = CHOP_CYC * MIX_PCT / 100;
  localparam int BLANK_NS = 3750;
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int OCP_QUAL_NS = 3000;
  localparam int OCP_CYC = (OCP_QUAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_US = 1000;
  localparam int WAKE_CYC = WAKE_US * 1000 / CLK_NS;
  // sense amplifier gain applied outside, ahead of the trip comparator
  localparam int SENSE_GAIN = 5;

  localparam logic [9:0] CHOP_LAST = 10'(CHOP_CYC - 1);
  localparam logic [9:0] MIX_AT = 10'(MIX_CYC);
  localparam logic [7:0] BLANK_LOAD = 8'(BLANK_CYC);
  localparam logic [7:0] OCP_LIMIT = 8'(OCP_CYC);
  localparam logic [1:0] LEVEL_OFF = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_DRIVE = 2'b00,
    PH_FAST  = 2'b01,
    PH_SLOW  = 2'b10,
    PH_OFF   = 2'b11
  } dbc_phase_e;

  typedef enum logic [1:0] {
    DEC_SLOW  = 2'b00,
    DEC_MIXED = 2'b01,
    DEC_FAST  = 2'b10
  } dbc_decay_e;

  typedef struct packed {
    logic ctl_first;
    logic ctl_second;
    logic current_level_msb;
    logic current_level_lsb;
    logic chop_trip;
    logic near_zero;
    logic switch_limit;
  } dbc_bridge_in_s;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } dbc_half_s;

  typedef struct packed {
    dbc_half_s drive_first;
    dbc_half_s drive_second;
  } dbc_bridge_s;

  typedef struct packed {
    dbc_bridge_in_s a;
    dbc_bridge_in_s b;
    logic decay_low;
    logic decay_high;
    logic logic_clear_n;
    logic low_power_request_n;
    logic overtemp_shutdown;
    logic supply_lockout;
  } dbc_pins_s;

endpackage

// ===== sim/dbc_host_model.sv
`timescale 1ns/1ps
module dbc_host_model #(
  parameter int WAKE = 8
) (
  // clock
  input wire logic i_mclk,
  // parallel control pins
  output dbc_pkg::dbc_pins_s o_pins
);
  // ------------------------
  // pin driver
  // ------------------------
  initial begin
    o_pins = '0;
    o_pins.logic_clear_n = 1'b1;
    o_pins.low_power_request_n = 1'b1;
  end

  // pins move a fixed step after the edge so no race with sampling
  task automatic apply(input dbc_pkg::dbc_pins_s p);
    @(posedge i_mclk);
    #2;
    o_pins = p;
  endtask

  // wake hold-off
  // host issues nothing until the wake delay has surely run out
  task automatic wake(input dbc_pkg::dbc_pins_s p);
    apply(p);
    repeat (WAKE + 8) @(posedge i_mclk);
  endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ------------------------
  // signals
  // ------------------------
  localparam int WAKE = 8;
  localparam logic [3:0] FWD = 4'h9;
  logic i_mclk;
  logic i_rst_n;
  dbc_pkg::dbc_pins_s p;
  dbc_pkg::dbc_pins_s pins;
  logic [3:0] drv_a;
  logic [3:0] drv_b;
  logic [1:0] ref_a;
  logic [1:0] ref_b;
  logic [1:0] arm;
  logic [1:0] overcurrent_shutdown;
  logic pump_en;
  logic reg_en;
  logic alert_n;
  logic alert_oe;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int k;

  dbc_host_model #(.WAKE(WAKE)) dbc_host_model_inst (
    .i_mclk(i_mclk),
    .o_pins(pins)
  );

  dbc_top #(.WAKE_CYC(WAKE)) dbc_top_inst (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_bridge_a(pins.a),
    .i_bridge_b(pins.b),
    .i_decay_low(pins.decay_low),
    .i_decay_high(pins.decay_high),
    .i_logic_clear_n(pins.logic_clear_n),
    .i_low_power_request_n(pins.low_power_request_n),
    .i_overtemp_shutdown(pins.overtemp_shutdown),
    .i_supply_lockout(pins.supply_lockout),
    .o_bridge_a_drive(drv_a),
    .o_bridge_b_drive(drv_b),
    .o_ref_scale_a(ref_a),
    .o_ref_scale_b(ref_b),
    .o_sense_arm(arm),
    .o_charge_pump_en(pump_en),
    .o_regulator_en(reg_en),
    .o_overcurrent_shutdown(overcurrent_shutdown),
    .o_protection_alert_n(alert_n),
    .o_protection_alert_oe(alert_oe)
  );

  // ------------------------
  // clock and watchdog
  // ------------------------
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  // ceiling well above the roughly 10k cycles the tests need
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ------------------------
  // tasks
  // ------------------------
  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // outputs trail the pins by five edges
  task automatic put();
    dbc_host_model_inst.apply(p);
    repeat (6) @(posedge i_mclk);
    #1;
  endtask

  // bridges come back once enabled; waits a whole chopping period before checks
  task automatic resume();
    dbc_host_model_inst.apply(p);
    repeat (dbc_pkg::CHOP_CYC + 16) @(posedge i_mclk);
    #1;
  endtask

  // counts cycles until bridge a does (eq) or leaves (!eq) pattern v
  task automatic wait_drv(input logic [3:0] v, input logic eq,
                          output int n);
    n = 0;
    while ((drv_a === v) != eq && n < 2000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (n == 2000) check(16'h0, 16'h1);
  endtask

  task automatic chop(input logic dl, input logic dh,
                      input logic [3:0] dec);
    int on;
    int n;
    int tail;
    tail = 0;
    p.decay_low = dl;
    p.decay_high = dh;
    p.a.chop_trip = 1'b1;
    dbc_host_model_inst.apply(p);
    // a measured period must open on a boundary, not on the enable edge
    wait_drv(FWD, 1'b1, n);
    wait_drv(FWD, 1'b0, n);
    wait_drv(FWD, 1'b1, n);
    @(posedge i_mclk);
    #1;
    check({14'h0, arm}, 16'h0);
    repeat (dbc_pkg::BLANK_CYC - 1) @(posedge i_mclk);
    #1;
    check({10'h0, arm, drv_a}, {10'h0, 2'b11, FWD});
    wait_drv(FWD, 1'b0, on);
    on = on + dbc_pkg::BLANK_CYC;
    check(16'(on >= dbc_pkg::BLANK_CYC && on <= dbc_pkg::BLANK_CYC + 4),
          16'h1);
    check({12'h0, drv_a}, {12'h0, dec});
    wait_drv(dec, 1'b0, n);
    if (!dl && !dh) begin
      check(16'(on + n >= dbc_pkg::MIX_CYC - 1 &&
                on + n <= dbc_pkg::MIX_CYC + 1), 16'h1);
      check({12'h0, drv_a}, 16'h5);
      wait_drv(4'h5, 1'b0, tail);
    end
    check(16'(on + n + tail), 16'(dbc_pkg::CHOP_CYC));
  endtask

  // ------------------------
  // test sequence
  // ------------------------
  initial begin
    i_rst_n = 1'b0;
    p = '0;
    p.logic_clear_n = 1'b1;
    p.low_power_request_n = 1'b1;
    p.decay_low = 1'b1;
    repeat (10) @(posedge i_mclk);
    #1;
    check({2'h0, alert_n, alert_oe, ref_a, ref_b, drv_a, drv_b},
          {2'h0, 2'b10, 4'hF, 8'h00});
    #1;
    i_rst_n = 1'b1;
    repeat (WAKE + 12) @(posedge i_mclk);
    for (int i = 0; i < 4; i++) begin
      p.a.ctl_first = i[1];
      p.a.ctl_second = i[0];
      p.b.ctl_first = i[0];
      p.b.ctl_second = i[1];
      put();
      check({8'h0, drv_a, drv_b}, {8'h0, i[1], ~i[1], i[0], ~i[0],
            i[0], ~i[0], i[1], ~i[1]});
    end
    for (int i = 0; i < 4; i++) begin
      {p.a.current_level_msb, p.a.current_level_lsb} = 2'(i);
      {p.b.current_level_msb, p.b.current_level_lsb} = 2'(3 - i);
      put();
      check({8'h0, ref_a, ref_b, drv_a, drv_b}, {8'h0, 2'(i), 2'(3 - i),
            (i == 3) ? 4'h0 : 4'hA, (i == 0) ? 4'h0 : 4'hA});
    end
    p.a = '0;
    p.b = '0;
    p.a.ctl_first = 1'b1;
    p.b.ctl_first = 1'b1;
    chop(1'b1, 1'b0, 4'h5);
    chop(1'b0, 1'b1, 4'h6);
    chop(1'b0, 1'b0, 4'h6);
    // near-zero current ends the reversed state
    p.decay_high = 1'b1;
    p.a.near_zero = 1'b1;
    dbc_host_model_inst.apply(p);
    wait_drv(FWD, 1'b1, k);
    wait_drv(FWD, 1'b0, k);
    wait_drv(4'h6, 1'b0, k);
    check({12'h0, drv_a}, 16'h0);
    p.a = '0;
    p.a.ctl_first = 1'b1;
    p.decay_low = 1'b1;
    p.decay_high = 1'b0;
    resume();
    // a limit shorter than qualification must not latch
    p.b.switch_limit = 1'b1;
    dbc_host_model_inst.apply(p);
    repeat (100) @(posedge i_mclk);
    p.b.switch_limit = 1'b0;
    put();
    check({4'h0, overcurrent_shutdown, alert_n, alert_oe, 8'h0}, 16'h0200);
    p.b.switch_limit = 1'b1;
    p.b.current_level_msb = 1'b1;
    dbc_host_model_inst.apply(p);
    repeat (dbc_pkg::OCP_CYC + 8) @(posedge i_mclk);
    #1;
    check({4'h0, overcurrent_shutdown, alert_n, alert_oe, drv_a, drv_b},
          {4'h0, 2'b10, 2'b01, FWD, 4'h0});
    p.b.switch_limit = 1'b0;
    resume();
    check({4'h0, overcurrent_shutdown, alert_n, alert_oe, drv_a, drv_b},
          {4'h0, 2'b10, 2'b01, FWD, 4'h0});
    p.logic_clear_n = 1'b0;
    put();
    check({8'h0, drv_a, drv_b}, 16'h0);
    p.logic_clear_n = 1'b1;
    resume();
    check({4'h0, overcurrent_shutdown, alert_n, alert_oe, drv_a, drv_b},
          {4'h0, 2'b00, 2'b10, FWD, FWD});
    p.overtemp_shutdown = 1'b1;
    put();
    check({6'h0, alert_n, alert_oe, drv_a, drv_b}, 16'h0100);
    p.overtemp_shutdown = 1'b0;
    resume();
    check({6'h0, alert_n, alert_oe, drv_a, drv_b},
          {6'h0, 2'b10, FWD, FWD});
    p.supply_lockout = 1'b1;
    put();
    check({4'h0, pump_en, reg_en, alert_n, alert_oe, drv_a, drv_b},
          16'h0100);
    p.supply_lockout = 1'b0;
    resume();
    check({4'h0, pump_en, reg_en, alert_n, alert_oe, drv_a, drv_b},
          {4'h0, 4'b1110, FWD, FWD});
    p.low_power_request_n = 1'b0;
    put();
    p.a.current_level_lsb = 1'b1;
    put();
    check({4'h0, pump_en, reg_en, ref_a, drv_a, drv_b}, 16'h0);
    p.low_power_request_n = 1'b1;
    dbc_host_model_inst.wake(p);
    resume();
    check({4'h0, pump_en, reg_en, ref_a, drv_a, drv_b},
          {4'h0, 4'b1101, FWD, FWD});
    close_out();
  end
endmodule
